/* shared/ppp_pkg.sv */
// constants shared by the parallel programming port and its memories
package ppp_pkg;
    // reference clock
    localparam int CLK_NS        = 4;

    // entry signature hold and self-timed write windows, in ns as specified
    localparam int ENTRY_HOLD_NS = 10_000;
    localparam int WRITE_MIN_NS  = 3_700_000;
    localparam int WRITE_MAX_NS  = 4_500_000;
    localparam int ERASE_MIN_NS  = 7_500_000;
    localparam int ERASE_MAX_NS  = 9_000_000;

    // least times round up, longest times round down
    localparam int ENTRY_CYC     = (ENTRY_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_MIN_CYC = (WRITE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_MAX_CYC = WRITE_MAX_NS / CLK_NS;
    localparam int ERASE_MIN_CYC = (ERASE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_MAX_CYC = ERASE_MAX_NS / CLK_NS;
    localparam int TIMER_W       = 22;
    localparam int ENTRY_W       = 12;

    // command byte codes
    localparam logic [7:0] CMD_NOP      = 8'h00;
    localparam logic [7:0] CMD_ERASE    = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EE    = 8'h11;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EE    = 8'h03;

    // action select coding for the load strobe
    localparam logic [1:0] ACT_ADDR     = 2'h0;
    localparam logic [1:0] ACT_DATA     = 2'h1;
    localparam logic [1:0] ACT_CMD      = 2'h2;

    // memory geometry
    localparam int FLASH_AW      = 12;
    localparam int FLASH_DEPTH   = 4096;
    localparam int EE_AW         = 9;
    localparam int EE_DEPTH      = 512;
    localparam int BUF_AW        = 5;
    localparam int BUF_DEPTH     = 32;
    localparam int FL_PAGE_LAST  = 31;
    localparam int EE_PAGE_LAST  = 3;
    localparam int EE_WORD_W     = 2;

    // fuse and lock values after power-up, erased contents
    localparam logic [7:0]  FUSE_LO_RST = 8'h62;
    localparam logic [7:0]  FUSE_HI_RST = 8'hff;
    localparam logic [7:0]  FUSE_EX_RST = 8'hff;
    localparam logic [7:0]  LOCK_RST    = 8'hff;
    localparam logic [7:0]  ERASED_BYTE = 8'hff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam int          EEPROM_PRESERVE_FUSE_BIT  = 3;
endpackage

/* src/nv_mem.sv */
// simple two-port memory with registered read data
`timescale 1ns/1ps
module nv_mem #(
    parameter int W  = 16,
    parameter int D  = 32,
    parameter int AW = 5
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] wa,
    input  wire logic [W-1:0]  wd,
    input  wire logic [AW-1:0] ra,
    output logic      [W-1:0]  rd
);
    logic [W-1:0] mem [D];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[wa] <= wd;
        end
        rd <= mem[ra];
    end
endmodule

/* src/parallel_program_port.sv */
// high-voltage parallel programming port: strobe decode, page buffer, self-timed writes
`timescale 1ns/1ps
// How it works
// - reset pin low exits programming mode
// - command and address kept between accesses
// - address high byte kept until reloaded
// - erase flash, then locks, then eeprom; fuses kept
// - preserve fuse keeps eeprom through erase
// - action 10, select 0 loads command
// - erase command plus write strobe erases
// - action 00 loads address low/high byte
// - action 01 loads data low/high byte
// - page latch stores data at word
// - command 0x10 selects paged flash write
// - low bits word, upper bits page
// - write strobe programs flash page, busy
// - nop command clears write activity
// - command 0x11 programs eeprom page
// - flash read returns low/high byte
// - eeprom read returns addressed byte
// - fuse command writes fuses from data
// - select bits pick high/extended fuse byte
// - ready low while busy, high idle
// - drive data only while output enable low
// - writes stay busy 3.7 to 4.5 ms
// - erase stays busy 7.5 to 9 ms
module parallel_program_port #(
    parameter int unsigned WRITE_CYC = ppp_pkg::WRITE_MIN_CYC,
    parameter int unsigned ERASE_CYC = ppp_pkg::ERASE_MIN_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       hv_reset_pin,
    input  wire logic       load_strobe_pin,
    input  wire logic       write_strobe_n,
    input  wire logic       output_enable_n,
    input  wire logic       byte_select_primary,
    input  wire logic       byte_select_secondary,
    input  wire logic       action_select_hi,
    input  wire logic       action_select_lo,
    input  wire logic       page_buffer_latch,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    output logic            ready_busy_out,
    output logic            prog_mode_active,
    output logic      [7:0] fuse_low,
    output logic      [7:0] fuse_high,
    output logic      [7:0] fuse_ext,
    output logic      [7:0] lock_bits
);
    typedef enum logic [1:0] {PM_OFF, PM_ENTRY, PM_ACTIVE} pmode_t;
    typedef enum logic [2:0] {OP_NONE, OP_ERASE, OP_FLASH, OP_EEPROM, OP_FUSE_LOCK} op_t;
    typedef enum logic [1:0] {SW_IDLE, SW_EFL, SW_EEE, SW_PAGE} sweep_t;

    typedef struct packed {
        logic       hv;
        logic       ls;
        logic       wr_n;
        logic       oe_n;
        logic       bs1;
        logic       bs2;
        logic       xa1;
        logic       xa0;
        logic       pl;
        logic [7:0] d;
    } pins_t;

    typedef struct packed {
        pins_t                      s1;
        pins_t                      s2;
        logic                       ls_q;
        logic                       wr_q;
        logic                       pl_q;
        logic                       hv_q;
        pmode_t                     pm;
        logic [ppp_pkg::ENTRY_W-1:0] ent_cnt;
        logic [7:0]                 cmd;
        logic [7:0]                 a_lo;
        logic [7:0]                 a_hi;
        logic [7:0]                 d_lo;
        logic [7:0]                 d_hi;
        op_t                        op;
        logic                       busy;
        logic [ppp_pkg::TIMER_W-1:0] timer;
        sweep_t                     sw;
        logic [12:0]                idx;
        logic                       pend;
        logic [4:0]                 pend_idx;
        logic [7:0]                 fuse_lo;
        logic [7:0]                 fuse_hi;
        logic [7:0]                 fuse_ex;
        logic [7:0]                 lock;
        logic                       rdy;
        logic                       doe;
        logic                       act;
        logic [7:0]                 dout;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic                         fl_we;
    logic [ppp_pkg::FLASH_AW-1:0] fl_wa;
    logic [15:0]                  fl_wd;
    logic [ppp_pkg::FLASH_AW-1:0] fl_ra;
    logic [15:0]                  fl_rd;
    logic                         ee_we;
    logic [ppp_pkg::EE_AW-1:0]    ee_wa;
    logic [7:0]                   ee_wd;
    logic [ppp_pkg::EE_AW-1:0]    ee_ra;
    logic [7:0]                   ee_rd;
    logic                         bf_we;
    logic [ppp_pkg::BUF_AW-1:0]   bf_wa;
    logic [15:0]                  bf_wd;
    logic [ppp_pkg::BUF_AW-1:0]   bf_ra;
    logic [15:0]                  bf_rd;

    logic                         ls_rise;
    logic                         wr_fall;
    logic                         pl_rise;
    logic                         hv_rise;
    logic                         active;
    logic [ppp_pkg::FLASH_AW-1:0] fl_addr;
    logic [ppp_pkg::EE_AW-1:0]    ee_addr;

    // edges are taken from the second synchroniser stage only
    assign ls_rise = st_r.s2.ls & ~st_r.ls_q;
    assign wr_fall = ~st_r.s2.wr_n & st_r.wr_q;
    assign pl_rise = st_r.s2.pl & ~st_r.pl_q;
    assign hv_rise = st_r.s2.hv & ~st_r.hv_q;
    assign active  = (st_r.pm == PM_ACTIVE);
    // upper bits of the low address byte join the high byte to form the page
    assign fl_addr = {st_r.a_hi[3:0], st_r.a_lo};
    assign ee_addr = {st_r.a_hi[0], st_r.a_lo};

    always_comb begin
        st_nxt = st_r;
        fl_we  = 1'b0;
        fl_wa  = fl_addr;
        fl_wd  = ppp_pkg::ERASED_WORD;
        fl_ra  = fl_addr;
        ee_we  = 1'b0;
        ee_wa  = ee_addr;
        ee_wd  = ppp_pkg::ERASED_BYTE;
        ee_ra  = ee_addr;
        bf_we  = 1'b0;
        bf_wa  = st_r.a_lo[4:0];
        bf_wd  = {st_r.d_hi, st_r.d_lo};
        bf_ra  = st_r.idx[4:0];

        st_nxt.s1 = '{hv: hv_reset_pin, ls: load_strobe_pin, wr_n: write_strobe_n,
                      oe_n: output_enable_n, bs1: byte_select_primary,
                      bs2: byte_select_secondary, xa1: action_select_hi,
                      xa0: action_select_lo, pl: page_buffer_latch, d: data_in};
        st_nxt.s2   = st_r.s1;
        st_nxt.ls_q = st_r.s2.ls;
        st_nxt.wr_q = st_r.s2.wr_n;
        st_nxt.pl_q = st_r.s2.pl;
        st_nxt.hv_q = st_r.s2.hv;

        case (st_r.pm)
            PM_OFF: begin
                if (hv_rise) begin
                    st_nxt.pm      = PM_ENTRY;
                    st_nxt.ent_cnt = '0;
                end
            end
            PM_ENTRY: begin
                st_nxt.ent_cnt = st_r.ent_cnt + 1'b1;
                // signature sampled once the programmer's hold time has passed
                if (st_r.ent_cnt == ppp_pkg::ENTRY_W'(ppp_pkg::ENTRY_CYC - 1)) begin
                    if ({st_r.s2.pl, st_r.s2.xa1, st_r.s2.xa0, st_r.s2.bs1} == 4'h0) begin
                        st_nxt.pm = PM_ACTIVE;
                    end else begin
                        st_nxt.pm = PM_OFF;
                    end
                end
            end
            PM_ACTIVE: begin
                st_nxt.pm = PM_ACTIVE;
            end
            default: begin
                st_nxt.pm = PM_OFF;
            end
        endcase

        // loads are refused while busy so a running page keeps its address
        if (active && !st_r.busy && ls_rise) begin
            case ({st_r.s2.xa1, st_r.s2.xa0})
                ppp_pkg::ACT_CMD: begin
                    if (!st_r.s2.bs1) begin
                        st_nxt.cmd = st_r.s2.d;
                    end
                end
                ppp_pkg::ACT_ADDR: begin
                    if (st_r.s2.bs1) begin
                        st_nxt.a_hi = st_r.s2.d;
                    end else begin
                        st_nxt.a_lo = st_r.s2.d;
                    end
                end
                ppp_pkg::ACT_DATA: begin
                    if (st_r.s2.bs1) begin
                        st_nxt.d_hi = st_r.s2.d;
                    end else begin
                        st_nxt.d_lo = st_r.s2.d;
                    end
                end
                default: begin
                    st_nxt.cmd = st_r.cmd;
                end
            endcase
        end

        if (active && !st_r.busy && pl_rise) begin
            bf_we = 1'b1;
            if (st_r.cmd == ppp_pkg::CMD_WR_EE) begin
                bf_wa = {3'h0, st_r.a_lo[ppp_pkg::EE_WORD_W-1:0]};
                bf_wd = {8'h00, st_r.d_lo};
            end
        end

        st_nxt.pend = 1'b0;
        if (!st_r.busy) begin
            if (active && wr_fall) begin
                case (st_r.cmd)
                    ppp_pkg::CMD_ERASE: begin
                        st_nxt.op    = OP_ERASE;
                        st_nxt.busy  = 1'b1;
                        st_nxt.timer = ppp_pkg::TIMER_W'(ERASE_CYC - 1);
                        st_nxt.sw    = SW_EFL;
                        st_nxt.idx   = '0;
                    end
                    ppp_pkg::CMD_WR_FLASH: begin
                        st_nxt.op    = OP_FLASH;
                        st_nxt.busy  = 1'b1;
                        st_nxt.timer = ppp_pkg::TIMER_W'(WRITE_CYC - 1);
                        st_nxt.sw    = SW_PAGE;
                        st_nxt.idx   = '0;
                    end
                    ppp_pkg::CMD_WR_EE: begin
                        if (!st_r.s2.bs1) begin
                            st_nxt.op    = OP_EEPROM;
                            st_nxt.busy  = 1'b1;
                            st_nxt.timer = ppp_pkg::TIMER_W'(WRITE_CYC - 1);
                            st_nxt.sw    = SW_PAGE;
                            st_nxt.idx   = '0;
                        end
                    end
                    ppp_pkg::CMD_WR_FUSE: begin
                        st_nxt.op    = OP_FUSE_LOCK;
                        st_nxt.busy  = 1'b1;
                        st_nxt.timer = ppp_pkg::TIMER_W'(WRITE_CYC - 1);
                        if (st_r.s2.bs1 && !st_r.s2.bs2) begin
                            st_nxt.fuse_hi = st_r.d_lo;
                        end else if (!st_r.s2.bs1 && st_r.s2.bs2) begin
                            st_nxt.fuse_ex = st_r.d_lo;
                        end else begin
                            st_nxt.fuse_lo = st_r.d_lo;
                        end
                    end
                    ppp_pkg::CMD_WR_LOCK: begin
                        st_nxt.op    = OP_FUSE_LOCK;
                        st_nxt.busy  = 1'b1;
                        st_nxt.timer = ppp_pkg::TIMER_W'(WRITE_CYC - 1);
                        // lock bits can only be programmed here, never cleared
                        st_nxt.lock  = st_r.lock & st_r.d_lo;
                    end
                    default: begin
                        st_nxt.op = OP_NONE;
                    end
                endcase
            end
        end else begin
            if (st_r.timer != '0) begin
                st_nxt.timer = st_r.timer - 1'b1;
            end
            case (st_r.sw)
                SW_EFL: begin
                    fl_we      = 1'b1;
                    fl_wa      = st_r.idx[ppp_pkg::FLASH_AW-1:0];
                    st_nxt.idx = st_r.idx + 1'b1;
                    if (st_r.idx == 13'(ppp_pkg::FLASH_DEPTH - 1)) begin
                        // locks fall only once the whole flash array is blank
                        st_nxt.lock = ppp_pkg::LOCK_RST;
                        st_nxt.idx  = '0;
                        st_nxt.sw   = st_r.fuse_hi[ppp_pkg::EEPROM_PRESERVE_FUSE_BIT] ? SW_EEE : SW_IDLE;
                    end
                end
                SW_EEE: begin
                    ee_we      = 1'b1;
                    ee_wa      = st_r.idx[ppp_pkg::EE_AW-1:0];
                    st_nxt.idx = st_r.idx + 1'b1;
                    if (st_r.idx == 13'(ppp_pkg::EE_DEPTH - 1)) begin
                        st_nxt.sw = SW_IDLE;
                    end
                end
                SW_PAGE: begin
                    st_nxt.pend     = 1'b1;
                    st_nxt.pend_idx = st_r.idx[4:0];
                    st_nxt.idx      = st_r.idx + 1'b1;
                    if ((st_r.op == OP_FLASH && st_r.idx == 13'(ppp_pkg::FL_PAGE_LAST)) ||
                        (st_r.op == OP_EEPROM && st_r.idx == 13'(ppp_pkg::EE_PAGE_LAST))) begin
                        st_nxt.sw = SW_IDLE;
                    end
                end
                default: begin
                    st_nxt.sw = SW_IDLE;
                end
            endcase
            // buffer data arrives one cycle after its read address
            if (st_r.pend) begin
                if (st_r.op == OP_FLASH) begin
                    fl_we = 1'b1;
                    fl_wa = {fl_addr[ppp_pkg::FLASH_AW-1:5], st_r.pend_idx};
                    fl_wd = bf_rd;
                end else begin
                    ee_we = 1'b1;
                    ee_wa = {ee_addr[ppp_pkg::EE_AW-1:2], st_r.pend_idx[1:0]};
                    ee_wd = bf_rd[7:0];
                end
            end
            if (st_r.timer == '0 && st_r.sw == SW_IDLE && !st_r.pend) begin
                st_nxt.busy = 1'b0;
                st_nxt.op   = OP_NONE;
            end
        end

        if (!st_r.s2.hv) begin
            st_nxt.pm   = PM_OFF;
            st_nxt.busy = 1'b0;
            st_nxt.op   = OP_NONE;
            st_nxt.sw   = SW_IDLE;
            st_nxt.pend = 1'b0;
        end

        // read path follows the held command and address
        st_nxt.dout = 8'hff;
        if (st_r.cmd == ppp_pkg::CMD_RD_FLASH) begin
            st_nxt.dout = st_r.s2.bs1 ? fl_rd[15:8] : fl_rd[7:0];
        end else if (st_r.cmd == ppp_pkg::CMD_RD_EE && !st_r.s2.bs1) begin
            st_nxt.dout = ee_rd;
        end
        st_nxt.doe = (st_nxt.pm == PM_ACTIVE) && !st_r.s2.oe_n;
        st_nxt.act = (st_nxt.pm == PM_ACTIVE);
        st_nxt.rdy = !st_nxt.busy;

        if (!rst_n) begin
            st_nxt         = '0;
            st_nxt.s1.wr_n = 1'b1;
            st_nxt.s2.wr_n = 1'b1;
            st_nxt.s1.oe_n = 1'b1;
            st_nxt.s2.oe_n = 1'b1;
            st_nxt.wr_q    = 1'b1;
            st_nxt.pm      = PM_OFF;
            st_nxt.op      = OP_NONE;
            st_nxt.sw      = SW_IDLE;
            st_nxt.fuse_lo = ppp_pkg::FUSE_LO_RST;
            st_nxt.fuse_hi = ppp_pkg::FUSE_HI_RST;
            st_nxt.fuse_ex = ppp_pkg::FUSE_EX_RST;
            st_nxt.lock    = ppp_pkg::LOCK_RST;
            st_nxt.rdy     = 1'b1;
            st_nxt.dout    = 8'hff;
            fl_we          = 1'b0;
            ee_we          = 1'b0;
            bf_we          = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        st_r <= st_nxt;
    end

    nv_mem #(.W(16), .D(ppp_pkg::FLASH_DEPTH), .AW(ppp_pkg::FLASH_AW)) u_flash (
        .clk (ref_clk),
        .we  (fl_we),
        .wa  (fl_wa),
        .wd  (fl_wd),
        .ra  (fl_ra),
        .rd  (fl_rd)
    );

    nv_mem #(.W(8), .D(ppp_pkg::EE_DEPTH), .AW(ppp_pkg::EE_AW)) u_eeprom (
        .clk (ref_clk),
        .we  (ee_we),
        .wa  (ee_wa),
        .wd  (ee_wd),
        .ra  (ee_ra),
        .rd  (ee_rd)
    );

    nv_mem #(.W(16), .D(ppp_pkg::BUF_DEPTH), .AW(ppp_pkg::BUF_AW)) u_page_buf (
        .clk (ref_clk),
        .we  (bf_we),
        .wa  (bf_wa),
        .wd  (bf_wd),
        .ra  (bf_ra),
        .rd  (bf_rd)
    );

    assign data_out         = st_r.dout;
    assign data_oe          = st_r.doe;
    assign ready_busy_out   = st_r.rdy;
    assign prog_mode_active = st_r.act;
    assign fuse_low         = st_r.fuse_lo;
    assign fuse_high        = st_r.fuse_hi;
    assign fuse_ext         = st_r.fuse_ex;
    assign lock_bits        = st_r.lock;

    // helper: length of each busy period and the operation behind it
    logic [ppp_pkg::TIMER_W-1:0] busy_len;
    op_t                         last_op;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy_len <= '0;
            last_op  <= OP_NONE;
        end else begin
            busy_len <= ready_busy_out ? '0 : busy_len + 1'b1;
            last_op  <= st_r.busy ? st_r.op : last_op;
        end
    end

    chk_write_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(ready_busy_out) && prog_mode_active && last_op != OP_ERASE |-> busy_len == WRITE_CYC)
        else $error("write busy period has the wrong length");
    chk_erase_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(ready_busy_out) && prog_mode_active && last_op == OP_ERASE |-> busy_len == ERASE_CYC)
        else $error("erase busy period has the wrong length");
    chk_busy_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
        active && st_r.rdy && wr_fall && st_r.s2.hv &&
        (st_r.cmd == ppp_pkg::CMD_ERASE || st_r.cmd == ppp_pkg::CMD_WR_FLASH) |=> (!ready_busy_out)[*2])
        else $error("write strobe did not drop ready");
    chk_wr_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_r.busy && wr_fall && st_r.s2.hv && st_r.timer > 1 |=> $stable(st_r.op) && !ready_busy_out)
        else $error("write strobe disturbed a running operation");
    chk_cmd_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        active && !st_r.busy && ls_rise && st_r.s2.xa1 && !st_r.s2.xa0 && !st_r.s2.bs1
        |=> st_r.cmd == $past(st_r.s2.d))
        else $error("command byte not captured");
    chk_addr_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        active && !st_r.busy && ls_rise && !st_r.s2.xa1 && !st_r.s2.xa0
        |=> ($past(st_r.s2.bs1) ? st_r.a_hi : st_r.a_lo) == $past(st_r.s2.d))
        else $error("address byte not captured");
    chk_bus_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        data_oe |-> prog_mode_active && !$past(st_r.s2.oe_n))
        else $error("data bus driven without output enable");
    chk_mode_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !st_r.s2.hv |=> !prog_mode_active && ready_busy_out)
        else $error("programming mode kept after reset pin dropped");
    chk_nop_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        active && st_r.rdy && wr_fall && st_r.cmd == ppp_pkg::CMD_NOP |=> ready_busy_out)
        else $error("no-operation command started a write");
    chk_preserve: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ee_we && st_r.op == OP_ERASE |-> st_r.fuse_hi[ppp_pkg::EEPROM_PRESERVE_FUSE_BIT])
        else $error("eeprom erased although preserve fuse programmed");
endmodule

/* testbench/prog_model.sv */
// programmer model: drives the port pins just after falling edges
`timescale 1ns/1ps
module prog_model (
    input  wire logic       ref_clk,
    output logic            hv_reset_pin,
    output logic            load_strobe_pin,
    output logic            write_strobe_n,
    output logic            output_enable_n,
    output logic            byte_select_primary,
    output logic            byte_select_secondary,
    output logic            action_select_hi,
    output logic            action_select_lo,
    output logic            page_buffer_latch,
    output logic      [7:0] data_in
);
    // entry signature pins all zero from time zero
    initial begin
        {hv_reset_pin, load_strobe_pin, page_buffer_latch, byte_select_secondary} = 4'h0;
        {write_strobe_n, output_enable_n} = 2'h3;
        {action_select_hi, action_select_lo, byte_select_primary} = 3'h0;
        data_in = 8'h00;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // 8 cycles each side, four times the two-stage pin synchroniser delay
    task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] b);
        {action_select_hi, action_select_lo} = act;
        byte_select_primary = bs1;
        data_in = b;
        wait_n(8);
        load_strobe_pin = 1'b1;
        wait_n(8);
        load_strobe_pin = 1'b0;
        wait_n(8);
        data_in = ~b;
    endtask
    // level pins that stay put between strobes
    task automatic levels(input logic hv, input logic oe_n, input logic bs1, input logic bs2);
        hv_reset_pin          = hv;
        output_enable_n       = oe_n;
        byte_select_primary   = bs1;
        byte_select_secondary = bs2;
    endtask
    task automatic latch();
        page_buffer_latch = 1'b1;
        wait_n(8);
        page_buffer_latch = 1'b0;
        wait_n(8);
    endtask
    task automatic pulse_wr();
        write_strobe_n = 1'b0;
        wait_n(8);
        write_strobe_n = 1'b1;
        wait_n(8);
    endtask
endmodule

/* testbench/tb_parallel_program_port.sv */
// bench: entry, erase, flash page write and read back, fuse write, exit
`timescale 1ns/1ps
module tb_parallel_program_port;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       hv_reset_pin, load_strobe_pin, write_strobe_n, output_enable_n, page_buffer_latch;
    logic       byte_select_primary, byte_select_secondary, action_select_hi, action_select_lo;
    logic [7:0] data_in, data_out, fuse_low, fuse_high, fuse_ext, lock_bits;
    logic       data_oe, ready_busy_out, prog_mode_active;
    int         fail_count = 0;
    int         check_count = 0;
    parallel_program_port #(.WRITE_CYC(40), .ERASE_CYC(5000)) u_parallel_program_port (.*);
    prog_model u_prog_model (.*);
    initial forever #2 ref_clk = ~ref_clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // busy must already show, then ready returns within a bound
    // extra pulses land while busy and must leave the running operation alone
    task automatic write_op(input int lim, input int pulses = 1);
        int n;
        n = 0;
        repeat (pulses) u_prog_model.pulse_wr();
        check({7'h0, ready_busy_out}, 8'h00);
        while (ready_busy_out !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        check({7'h0, ready_busy_out}, 8'h01);
    endtask
    initial begin
        #390_000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        check(fuse_low, 8'h62);
        u_prog_model.levels(1'b1, 1'b1, 1'b0, 1'b0);
        u_prog_model.wait_n(75_000);
        check({7'h0, prog_mode_active}, 8'h01);
        u_prog_model.load(2'h2, 1'b0, 8'h80);
        write_op(6000);
        check(lock_bits, 8'hff);
        u_prog_model.load(2'h2, 1'b0, 8'h10);
        u_prog_model.load(2'h0, 1'b0, 8'h05);
        u_prog_model.load(2'h1, 1'b0, 8'h34);
        u_prog_model.load(2'h1, 1'b1, 8'h12);
        u_prog_model.latch();
        u_prog_model.load(2'h0, 1'b1, 8'h01);
        write_op(100);
        u_prog_model.load(2'h2, 1'b0, 8'h02);
        u_prog_model.levels(1'b1, 1'b0, 1'b0, 1'b0);
        u_prog_model.wait_n(8);
        check({7'h0, data_oe}, 8'h01);
        check(data_out, 8'h34);
        u_prog_model.levels(1'b1, 1'b0, 1'b1, 1'b0);
        u_prog_model.wait_n(8);
        check(data_out, 8'h12);
        u_prog_model.levels(1'b1, 1'b1, 1'b0, 1'b0);
        u_prog_model.wait_n(8);
        check({7'h0, data_oe}, 8'h00);
        u_prog_model.load(2'h2, 1'b0, 8'h40);
        u_prog_model.load(2'h1, 1'b0, 8'ha5);
        u_prog_model.levels(1'b1, 1'b1, 1'b1, 1'b0);
        write_op(100);
        check(fuse_high, 8'ha5);
        check(fuse_low, 8'h62);
        u_prog_model.load(2'h1, 1'b0, 8'h5a);
        u_prog_model.levels(1'b1, 1'b1, 1'b0, 1'b1);
        write_op(100);
        check(fuse_ext, 8'h5a);
        u_prog_model.levels(1'b1, 1'b1, 1'b0, 1'b0);
        u_prog_model.load(2'h2, 1'b0, 8'h20);
        u_prog_model.load(2'h1, 1'b0, 8'hfc);
        write_op(100);
        check(lock_bits, 8'hfc);
        u_prog_model.load(2'h2, 1'b0, 8'h00);
        u_prog_model.pulse_wr();
        check({7'h0, ready_busy_out}, 8'h01);
        u_prog_model.load(2'h2, 1'b0, 8'h11);
        u_prog_model.load(2'h0, 1'b0, 8'h07);
        u_prog_model.load(2'h1, 1'b0, 8'h3c);
        u_prog_model.latch();
        write_op(100);
        u_prog_model.load(2'h2, 1'b0, 8'h03);
        u_prog_model.levels(1'b1, 1'b0, 1'b0, 1'b0);
        u_prog_model.wait_n(8);
        check(data_out, 8'h3c);
        u_prog_model.levels(1'b1, 1'b1, 1'b0, 1'b0);
        u_prog_model.load(2'h2, 1'b0, 8'h80);
        write_op(6000, 2);
        check(lock_bits, 8'hff);
        u_prog_model.load(2'h2, 1'b0, 8'h03);
        u_prog_model.levels(1'b1, 1'b0, 1'b0, 1'b0);
        u_prog_model.wait_n(8);
        check(data_out, 8'h3c);
        u_prog_model.levels(1'b0, 1'b1, 1'b0, 1'b0);
        u_prog_model.wait_n(8);
        check({7'h0, prog_mode_active}, 8'h00);
        report_and_stop();
    end
endmodule
